// ---- hw/cdisj_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cdisj_regs.svh"

module cdisj_exec #(
	parameter int SKIP_CYCLES = `CDISJ_SKIP_CYCLES,
	parameter int JUMP_CYCLES = `CDISJ_JUMP_CYCLES
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       op_valid_i,
	input  wire cdisj_pkg::cdisj_op_t       op_i,
	input  wire logic [`CDISJ_ADDR_W-1:0]   file_addr_i,
	input  wire logic                       dest_i,
	input  wire logic [`CDISJ_DATA_W-1:0]   file_data_i,
	input  wire logic [`CDISJ_IMM_W-1:0]    imm_i,
	input  wire logic [`CDISJ_UPPER_W-1:0]  upper_pc_holding_reg_i,
	output logic                            ready_o,
	output logic                            reg_we_o,
	output logic [`CDISJ_ADDR_W-1:0]        reg_addr_o,
	output logic [`CDISJ_DATA_W-1:0]        reg_wdata_o,
	output logic                            acc_we_o,
	output logic [`CDISJ_DATA_W-1:0]        acc_wdata_o,
	output logic                            result_null_flag_we_o,
	output logic                            result_null_flag_o,
	output logic                            pc_load_o,
	output logic [`CDISJ_PC_W-1:0]          pc_o,
	output logic                            discard_o
);

	////////////////////////////////////////////////////////////////////////
	// counter width covers the longest instruction
	localparam int MAX_CYC = (SKIP_CYCLES > JUMP_CYCLES) ? SKIP_CYCLES : JUMP_CYCLES;
	localparam int CNT_W   = (MAX_CYC > 2) ? $clog2(MAX_CYC) : 1;

	// extra cycles after the first one, never below one
	localparam logic [CNT_W-1:0] SKIP_EXTRA =
		CNT_W'((SKIP_CYCLES > 1) ? SKIP_CYCLES - 1 : 1);
	localparam logic [CNT_W-1:0] JUMP_EXTRA =
		CNT_W'((JUMP_CYCLES > 1) ? JUMP_CYCLES - 1 : 1);

	////////////////////////////////////////////////////////////////////////
	// state and output registers
	cdisj_pkg::cdisj_state_t       state_r, state_nxt;
	logic [CNT_W-1:0]              cnt_r, cnt_nxt;
	logic                          ready_r, ready_nxt;
	logic                          reg_we_r, reg_we_nxt;
	logic [`CDISJ_ADDR_W-1:0]      reg_addr_r, reg_addr_nxt;
	logic [`CDISJ_DATA_W-1:0]      reg_wdata_r, reg_wdata_nxt;
	logic                          acc_we_r, acc_we_nxt;
	logic [`CDISJ_DATA_W-1:0]      acc_wdata_r, acc_wdata_nxt;
	logic                          z_we_r, z_we_nxt;
	logic                          z_r, z_nxt;
	logic                          pc_load_r, pc_load_nxt;
	logic [`CDISJ_PC_W-1:0]        pc_r, pc_nxt;
	logic                          discard_r, discard_nxt;

	logic                          take;
	logic [`CDISJ_PC_W-1:0]        jump_target;

	cdisj_alu_if alu_bus ();

	////////////////////////////////////////////////////////////////////////
	// jump target assembly, shared with anyone who later adds a call
	function automatic logic [`CDISJ_PC_W-1:0] jump_pc(
		input logic [`CDISJ_UPPER_W-1:0] upper,
		input logic [`CDISJ_IMM_W-1:0]   imm
	);
		// the wider 6:3 field is used, not the narrower 4:3 one
		jump_pc = {upper[`CDISJ_UPPER_MSB:`CDISJ_UPPER_LSB], imm};
	endfunction

	// an op is only taken while no second cycle is pending
	assign take        = op_valid_i && (state_r == cdisj_pkg::ST_IDLE);
	assign jump_target = jump_pc(upper_pc_holding_reg_i, imm_i);

	// datapath feeds; an op offered while stalled is seen as no op
	assign alu_bus.op      = take ? op_i : cdisj_pkg::OP_NONE;
	assign alu_bus.operand = file_data_i;
	assign alu_bus.dest    = dest_i;

	cdisj_alu u_alu (
		.bus (alu_bus.alu)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: one idle state, one state for the discarded slot
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			cdisj_pkg::ST_IDLE: begin
				if (take && (op_i == cdisj_pkg::OP_JUMP)) begin
					state_nxt = cdisj_pkg::ST_STALL;
					cnt_nxt   = JUMP_EXTRA;
				end else if (alu_bus.skip) begin
					state_nxt = cdisj_pkg::ST_STALL;
					cnt_nxt   = SKIP_EXTRA;
				end
			end
			cdisj_pkg::ST_STALL: begin
				if (cnt_r <= CNT_W'(1)) begin
					state_nxt = cdisj_pkg::ST_IDLE;
					cnt_nxt   = '0;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			default: begin
				state_nxt = cdisj_pkg::ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	// ready is low exactly while the discarded slot is running
	always_comb begin
		ready_nxt = (state_nxt == cdisj_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= cdisj_pkg::ST_IDLE;
			cnt_r   <= '0;
			ready_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-back strobes: one-cycle pulses, data held until the next write to it
	always_comb begin
		reg_we_nxt    = alu_bus.reg_we;
		reg_addr_nxt  = reg_addr_r;
		reg_wdata_nxt = reg_wdata_r;
		acc_we_nxt    = alu_bus.acc_we;
		acc_wdata_nxt = acc_wdata_r;
		z_we_nxt      = alu_bus.z_we;                     // skip ops never touch it
		z_nxt         = z_r;
		if (alu_bus.reg_we) begin
			reg_addr_nxt  = file_addr_i;
			reg_wdata_nxt = alu_bus.result;
		end
		if (alu_bus.acc_we) begin
			acc_wdata_nxt = alu_bus.result;
		end
		if (alu_bus.z_we) begin
			z_nxt = alu_bus.z_val;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_we_r    <= 1'b0;
			reg_addr_r  <= `CDISJ_ZERO_ADDR;
			reg_wdata_r <= `CDISJ_ZERO_BYTE;
			acc_we_r    <= 1'b0;
			acc_wdata_r <= `CDISJ_ZERO_BYTE;
			z_we_r      <= 1'b0;
			z_r         <= 1'b0;
		end else begin
			reg_we_r    <= reg_we_nxt;
			reg_addr_r  <= reg_addr_nxt;
			reg_wdata_r <= reg_wdata_nxt;
			acc_we_r    <= acc_we_nxt;
			acc_wdata_r <= acc_wdata_nxt;
			z_we_r      <= z_we_nxt;
			z_r         <= z_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter load and prefetch discard
	always_comb begin
		pc_load_nxt = take && (op_i == cdisj_pkg::OP_JUMP);
		pc_nxt      = pc_r;
		// discard marks the prefetched word as a nop for the core
		discard_nxt = pc_load_nxt || alu_bus.skip;
		if (pc_load_nxt) begin
			pc_nxt = jump_target;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_load_r <= 1'b0;
			pc_r      <= `CDISJ_ZERO_PC;
			discard_r <= 1'b0;
		end else begin
			pc_load_r <= pc_load_nxt;
			pc_r      <= pc_nxt;
			discard_r <= discard_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign ready_o               = ready_r;
	assign reg_we_o              = reg_we_r;
	assign reg_addr_o            = reg_addr_r;
	assign reg_wdata_o           = reg_wdata_r;
	assign acc_we_o              = acc_we_r;
	assign acc_wdata_o           = acc_wdata_r;
	assign result_null_flag_we_o = z_we_r;
	assign result_null_flag_o    = z_r;
	assign pc_load_o             = pc_load_r;
	assign pc_o                  = pc_r;
	assign discard_o             = discard_r;

endmodule

`default_nettype wire

// ---- hw/cdisj_regs.svh ----
`ifndef CDISJ_REGS_SVH
`define CDISJ_REGS_SVH

// field widths of the instruction operands
`define CDISJ_ADDR_W      7
`define CDISJ_DATA_W      8
`define CDISJ_IMM_W       11
`define CDISJ_PC_W        15
`define CDISJ_UPPER_W     7

// upper program counter source bits inside the holding register
`define CDISJ_UPPER_MSB   6
`define CDISJ_UPPER_LSB   3

// reset and cleared values
`define CDISJ_ZERO_BYTE   8'h00
`define CDISJ_ZERO_PC     15'h0000
`define CDISJ_ZERO_ADDR   7'h00

// instruction lengths in instruction cycles
`define CDISJ_SKIP_CYCLES 2
`define CDISJ_JUMP_CYCLES 2

`endif

// ---- hw/cdisj_pkg.sv ----
`default_nettype none
package cdisj_pkg;

	// operation issued by the core for this slice
	typedef enum logic [2:0] {
		OP_NONE,
		OP_CLR_REG,
		OP_CLR_ACC,
		OP_DEC,
		OP_DEC_SKIP,
		OP_INC_SKIP,
		OP_JUMP
	} cdisj_op_t;

	// sequencer states
	typedef enum logic {
		ST_IDLE,
		ST_STALL
	} cdisj_state_t;

endpackage

`default_nettype wire

// ---- hw/cdisj_alu_if.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cdisj_regs.svh"

// operands in, results and write strobes out of the datapath
interface cdisj_alu_if;
	cdisj_pkg::cdisj_op_t        op;
	logic [`CDISJ_DATA_W-1:0]    operand;
	logic                        dest;
	logic [`CDISJ_DATA_W-1:0]    result;
	logic                        reg_we;
	logic                        acc_we;
	logic                        z_we;
	logic                        z_val;
	logic                        skip;

	modport alu (
		input  op,
		input  operand,
		input  dest,
		output result,
		output reg_we,
		output acc_we,
		output z_we,
		output z_val,
		output skip
	);

	modport core (
		output op,
		output operand,
		output dest,
		input  result,
		input  reg_we,
		input  acc_we,
		input  z_we,
		input  z_val,
		input  skip
	);
endinterface

`default_nettype wire

// ---- hw/cdisj_alu.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cdisj_regs.svh"

module cdisj_alu (
	cdisj_alu_if.alu bus
);

	////////////////////////////////////////////////////////////////////////
	// datapath: result, destination strobes, zero flag, skip request
	always_comb begin
		bus.result = `CDISJ_ZERO_BYTE;
		bus.reg_we = 1'b0;
		bus.acc_we = 1'b0;
		bus.z_we   = 1'b0;
		bus.z_val  = 1'b0;
		bus.skip   = 1'b0;
		case (bus.op)
			cdisj_pkg::OP_CLR_REG: begin
				bus.result = `CDISJ_ZERO_BYTE;
				bus.reg_we = 1'b1;
				bus.z_we   = 1'b1;
				bus.z_val  = 1'b1;
			end
			cdisj_pkg::OP_CLR_ACC: begin
				bus.result = `CDISJ_ZERO_BYTE;
				bus.acc_we = 1'b1;
				bus.z_we   = 1'b1;
				bus.z_val  = 1'b1;
			end
			cdisj_pkg::OP_DEC: begin
				bus.result = bus.operand - 8'h01;
				bus.reg_we = bus.dest;
				bus.acc_we = ~bus.dest;
				bus.z_we   = 1'b1;
				bus.z_val  = (bus.result == `CDISJ_ZERO_BYTE);
			end
			cdisj_pkg::OP_DEC_SKIP: begin
				bus.result = bus.operand - 8'h01;
				bus.reg_we = bus.dest;
				bus.acc_we = ~bus.dest;
				bus.skip   = (bus.result == `CDISJ_ZERO_BYTE); // flag left alone
			end
			cdisj_pkg::OP_INC_SKIP: begin
				bus.result = bus.operand + 8'h01;
				bus.reg_we = bus.dest;
				bus.acc_we = ~bus.dest;
				bus.skip   = (bus.result == `CDISJ_ZERO_BYTE); // flag left alone
			end
			default: begin
				bus.result = `CDISJ_ZERO_BYTE;
			end
		endcase
	end

endmodule

`default_nettype wire

// ---- sim/cdisj_exec_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cdisj_regs.svh"
module cdisj_exec_assertions #(
	parameter int SKIP_CYCLES = 2,
	parameter int JUMP_CYCLES = 2
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 op_valid_i,
	input wire cdisj_pkg::cdisj_op_t op_i,
	input wire logic [6:0]           file_addr_i,
	input wire logic                 dest_i,
	input wire logic [7:0]           file_data_i,
	input wire logic [10:0]          imm_i,
	input wire logic [6:0]           upper_pc_holding_reg_i,
	input wire logic                 ready_o,
	input wire logic                 reg_we_o,
	input wire logic [6:0]           reg_addr_o,
	input wire logic [7:0]           reg_wdata_o,
	input wire logic                 acc_we_o,
	input wire logic [7:0]           acc_wdata_o,
	input wire logic                 result_null_flag_we_o,
	input wire logic                 result_null_flag_o,
	input wire logic                 pc_load_o,
	input wire logic [14:0]          pc_o,
	input wire logic                 discard_o
);
	// upper pc source and the take condition, kept as nets so $past sees plain signals
	wire logic [3:0] up_hi = upper_pc_holding_reg_i[6:3];
	wire logic       tk    = op_valid_i && ready_o;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	AST_CLR_REG: assert property (tk && op_i == cdisj_pkg::OP_CLR_REG |=> reg_we_o
		&& reg_wdata_o == 8'h00 && reg_addr_o == $past(file_addr_i) && result_null_flag_o)
		else $error("register clear wrong");
	AST_CLR_ACC: assert property (tk && op_i == cdisj_pkg::OP_CLR_ACC |=> acc_we_o
		&& acc_wdata_o == 8'h00 && result_null_flag_we_o && result_null_flag_o)
		else $error("accumulator clear wrong");
	AST_DEC_FLAG: assert property (tk && op_i == cdisj_pkg::OP_DEC |=>
		result_null_flag_we_o && result_null_flag_o == ($past(file_data_i) == 8'h01))
		else $error("dec flag wrong");
	AST_DEST: assert property (tk && op_i inside {cdisj_pkg::OP_DEC,
		cdisj_pkg::OP_DEC_SKIP, cdisj_pkg::OP_INC_SKIP} |=> reg_we_o == $past(dest_i)
		&& acc_we_o != $past(dest_i)) else $error("destination wrong");
	AST_SKIP_FLAG: assert property (tk && op_i inside {cdisj_pkg::OP_DEC_SKIP,
		cdisj_pkg::OP_INC_SKIP} |=> !result_null_flag_we_o) else $error("skip wrote flag");
	AST_DEC_SKIP: assert property (tk && op_i == cdisj_pkg::OP_DEC_SKIP |=>
		discard_o == ($past(file_data_i) == 8'h01)) else $error("dec skip wrong");
	AST_INC_SKIP: assert property (tk && op_i == cdisj_pkg::OP_INC_SKIP |=>
		discard_o == ($past(file_data_i) == 8'hff)) else $error("inc skip wrong");
	AST_JUMP_PC: assert property (tk && op_i == cdisj_pkg::OP_JUMP |=> pc_load_o
		&& pc_o == {$past(up_hi), $past(imm_i)}) else $error("jump target wrong");
	AST_JUMP_SLOT: assert property (tk && op_i == cdisj_pkg::OP_JUMP |=>
		discard_o && !ready_o ##1 ready_o) else $error("jump slot wrong");
	AST_SKIP_KEEP: assert property (tk && op_i inside {cdisj_pkg::OP_DEC_SKIP,
		cdisj_pkg::OP_INC_SKIP} |=> $stable(result_null_flag_o)) else $error("skip moved flag");
	// an op offered in the dead slot must leave no pulse at all
	AST_SLOT_QUIET: assert property (!ready_o |=> !reg_we_o && !acc_we_o
		&& !result_null_flag_we_o && !pc_load_o && !discard_o) else $error("stalled op taken");
endmodule

bind cdisj_exec cdisj_exec_assertions #(.SKIP_CYCLES(SKIP_CYCLES), .JUMP_CYCLES(JUMP_CYCLES))
	chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
	.file_addr_i(file_addr_i), .dest_i(dest_i), .file_data_i(file_data_i), .imm_i(imm_i),
	.upper_pc_holding_reg_i(upper_pc_holding_reg_i), .ready_o(ready_o), .reg_we_o(reg_we_o),
	.reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .acc_we_o(acc_we_o),
	.acc_wdata_o(acc_wdata_o), .result_null_flag_we_o(result_null_flag_we_o),
	.result_null_flag_o(result_null_flag_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
	.discard_o(discard_o));
`default_nettype wire

// ---- sim/cdisj_exec_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cdisj_regs.svh"
module cdisj_exec_bench;
	logic                 clk_i                  = 1'b0;
	logic                 rst_i                  = 1'b1;
	logic                 op_valid_i             = 1'b0;
	cdisj_pkg::cdisj_op_t op_i                   = cdisj_pkg::OP_NONE;
	logic [6:0]           file_addr_i            = 7'h00;
	logic                 dest_i                 = 1'b0;
	logic [7:0]           file_data_i            = 8'h00;
	logic [10:0]          imm_i                  = 11'h000;
	logic [6:0]           upper_pc_holding_reg_i = 7'h00;
	logic                 ready_o, reg_we_o, acc_we_o, result_null_flag_we_o;
	logic                 result_null_flag_o, pc_load_o, discard_o;
	logic [6:0]           reg_addr_o;
	logic [7:0]           reg_wdata_o, acc_wdata_o;
	logic [14:0]          pc_o;
	logic [43:0]          exp_q[$];
	logic [43:0]          seen;
	logic [43:0]          want;
	int                   error_cnt = 0;
	int                   checks = 0;
	int                   cyc = 0;

	cdisj_exec dut_u (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.op_valid_i             (op_valid_i),
		.op_i                   (op_i),
		.file_addr_i            (file_addr_i),
		.dest_i                 (dest_i),
		.file_data_i            (file_data_i),
		.imm_i                  (imm_i),
		.upper_pc_holding_reg_i (upper_pc_holding_reg_i),
		.ready_o                (ready_o),
		.reg_we_o               (reg_we_o),
		.reg_addr_o             (reg_addr_o),
		.reg_wdata_o            (reg_wdata_o),
		.acc_we_o               (acc_we_o),
		.acc_wdata_o            (acc_wdata_o),
		.result_null_flag_we_o  (result_null_flag_we_o),
		.result_null_flag_o     (result_null_flag_o),
		.pc_load_o              (pc_load_o),
		.pc_o                   (pc_o),
		.discard_o              (discard_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// free running clock, hang cut off well beyond the roughly 160 cycles used
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic cmp(string nm, logic [43:0] e, logic [43:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// offer one op, note its expected outputs; with refuse set, also offer OP_CLR_ACC during the dead slot
	task automatic do_op(cdisj_pkg::cdisj_op_t op, logic [6:0] a, logic d, logic [7:0] v,
		logic [10:0] k, logic [6:0] u, logic refuse);
		logic [7:0]  r;
		logic [43:0] e;
		logic        dc;
		dc = op == cdisj_pkg::OP_DEC;
		r = (op == cdisj_pkg::OP_INC_SKIP) ? v + 8'h01 : v - 8'h01;
		e = {d, !d, dc, 1'b0, !dc && r == 8'h00, d ? a : 7'h00, d ? r : 8'h00,
			d ? 8'h00 : r, dc && r == 8'h00, 15'h0000};
		if (op == cdisj_pkg::OP_CLR_REG) e = {5'b10100, a, 16'h0000, 1'b1, 15'h0000};
		if (op == cdisj_pkg::OP_CLR_ACC) e = {5'b01100, 23'h000000, 1'b1, 15'h0000};
		if (op == cdisj_pkg::OP_JUMP) e = {5'b00011, 24'h000000, u[6:3], k};
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_i <= op;
		file_addr_i <= a;
		dest_i <= d;
		file_data_i <= v;
		imm_i <= k;
		upper_pc_holding_reg_i <= u;
		if (op != cdisj_pkg::OP_NONE) exp_q.push_back(e);
		@(posedge clk_i);
		// a refused offer must leave no trace, so nothing is queued for it
		if (refuse) begin
			op_i <= cdisj_pkg::OP_CLR_ACC;
			@(posedge clk_i);
		end
		op_valid_i <= 1'b0;
	endtask

	// monitor: any pulse is one result, checked against the oldest note
	always @(negedge clk_i) begin
		if (!rst_i && (reg_we_o || acc_we_o || result_null_flag_we_o || pc_load_o || discard_o)) begin
			seen = {reg_we_o, acc_we_o, result_null_flag_we_o, pc_load_o, discard_o,
				reg_we_o ? reg_addr_o : 7'h00, reg_we_o ? reg_wdata_o : 8'h00,
				acc_we_o ? acc_wdata_o : 8'h00, result_null_flag_we_o & result_null_flag_o,
				pc_load_o ? pc_o : 15'h0000};
			want = exp_q.size() ? exp_q.pop_front() : 44'h0;
			cmp("result", want, seen);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(74));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp("ready", 44'h1, {43'h0, ready_o});
		cmp("flag", 44'h0, {43'h0, result_null_flag_o});
		do_op(cdisj_pkg::OP_CLR_REG, 7'h7f, 1'b1, 8'h5a, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_CLR_ACC, 7'h00, 1'b0, 8'h5a, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_DEC, 7'h11, 1'b0, 8'h01, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_DEC, 7'h12, 1'b1, 8'h00, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_DEC_SKIP, 7'h13, 1'b1, 8'h01, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_DEC_SKIP, 7'h14, 1'b0, 8'h05, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_INC_SKIP, 7'h15, 1'b0, 8'hff, 11'h000, 7'h00, 1'b1);
		do_op(cdisj_pkg::OP_INC_SKIP, 7'h16, 1'b1, 8'h7f, 11'h000, 7'h00, 1'b0);
		do_op(cdisj_pkg::OP_JUMP, 7'h00, 1'b0, 8'h00, 11'h7ff, 7'h78, 1'b1);
		do_op(cdisj_pkg::OP_JUMP, 7'h00, 1'b0, 8'h00, 11'h000, 7'h07, 1'b0);
		do_op(cdisj_pkg::OP_NONE, 7'h01, 1'b1, 8'h01, 11'h001, 7'h01, 1'b0);
		$display("test directed done");
		repeat (60) begin
			do_op(cdisj_pkg::cdisj_op_t'(3'($urandom_range(6))), 7'($urandom), 1'($urandom),
				8'($urandom_range(3) == 0 ? 1 : $urandom), 11'($urandom), 7'($urandom), 1'b0);
		end
		$display("test random done");
		repeat (4) @(posedge clk_i);
		// reset in mid-run, then the block must work again from clean state
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp("reset state", {27'h0, 1'b1, 1'b0, 15'h0000},
			{27'h0, ready_o, result_null_flag_o, pc_o});
		do_op(cdisj_pkg::OP_DEC, 7'h21, 1'b1, 8'h01, 11'h000, 7'h00, 1'b0);
		$display("test reset done");
		repeat (4) @(posedge clk_i);
		cmp("pending", 44'h0, 44'(exp_q.size()));
		give_verdict();
	end
endmodule
`default_nettype wire
